// >>> hdl/iep_pkg.sv
package iep_pkg;
	localparam int DW = 16;
	localparam int FW = 3;
	localparam int NIB = 4;
	localparam logic [11:0] OFS_EN4 = 12'h000;
	localparam logic [11:0] OFS_EN5 = 12'h004;
	localparam logic [11:0] OFS_PR0 = 12'h008;
	localparam logic [11:0] OFS_PR1 = 12'h00C;
	localparam logic [11:0] OFS_PR2 = 12'h010;
	localparam logic [11:0] OFS_STAT = 12'h014;
	localparam logic [11:0] OFS_MASK = 12'h018;
	// enable bit positions
	localparam int CHARGE_TIME_IRQ_EN = 13;
	localparam int LOW_VOLTAGE_IRQ_EN = 8;
	localparam int CRC_GEN_IRQ_EN = 3;
	localparam int SERIAL2_ERROR_IRQ_EN = 2;
	localparam int SERIAL1_ERROR_IRQ_EN = 1;
	localparam int CAPTURE9_IRQ_EN = 13;
	localparam int COMPARE9_IRQ_EN = 12;
	localparam int SPI_THIRD_EVENT_IRQ_EN = 11;
	localparam int SPI_THIRD_FAULT_IRQ_EN = 10;
	localparam int SERIAL4_TX_IRQ_EN = 9;
	localparam int SERIAL4_RX_IRQ_EN = 8;
	localparam int SERIAL4_ERROR_IRQ_EN = 7;
	localparam int USB_IRQ_EN = 6;
	localparam int I2C_THIRD_MASTER_IRQ_EN = 5;
	localparam int I2C_THIRD_SLAVE_IRQ_EN = 4;
	localparam int SERIAL3_TX_IRQ_EN = 3;
	localparam int SERIAL3_RX_IRQ_EN = 2;
	localparam int SERIAL3_ERROR_IRQ_EN = 1;
	localparam logic [15:0] MASK_EN4 = 16'((1 << CHARGE_TIME_IRQ_EN)
		| (1 << LOW_VOLTAGE_IRQ_EN) | (1 << CRC_GEN_IRQ_EN)
		| (1 << SERIAL2_ERROR_IRQ_EN) | (1 << SERIAL1_ERROR_IRQ_EN));
	localparam logic [15:0] MASK_EN5 = 16'((1 << CAPTURE9_IRQ_EN)
		| (1 << COMPARE9_IRQ_EN) | (1 << SPI_THIRD_EVENT_IRQ_EN)
		| (1 << SPI_THIRD_FAULT_IRQ_EN) | (1 << SERIAL4_TX_IRQ_EN)
		| (1 << SERIAL4_RX_IRQ_EN) | (1 << SERIAL4_ERROR_IRQ_EN)
		| (1 << USB_IRQ_EN) | (1 << I2C_THIRD_MASTER_IRQ_EN)
		| (1 << I2C_THIRD_SLAVE_IRQ_EN) | (1 << SERIAL3_TX_IRQ_EN)
		| (1 << SERIAL3_RX_IRQ_EN) | (1 << SERIAL3_ERROR_IRQ_EN));
	// three-bit field in each nibble except the low nibble of word one, top bit of nibble unused
	localparam logic [15:0] MASK_PR0 = 16'h7777;
	localparam logic [15:0] MASK_PR1 = 16'h7770;
	localparam logic [15:0] MASK_PR2 = 16'h7777;
	localparam logic [15:0] RESV_PR = 16'h8888;
	localparam logic [15:0] RST_EN = 16'h0000;
	localparam logic [15:0] RST_PR = 16'h4444;
	localparam logic [2:0] PRIO_OFF = 3'h0;
	localparam logic [2:0] PRIO_LOW = 3'h1;
	localparam logic [2:0] PRIO_TOP = 3'h7;
	localparam int ST_PRIO = 0;
	localparam int ST_GATE = 1;
	localparam int ST_W = 2;
	localparam logic [1:0] RST_ST = 2'h0;
endpackage

// >>> hdl/iep_regs.sv
// Functional notes
// - enable one passes request, zero blocks
// - field 111 gives level 7, highest
// - field 001 is level 1, others direct
// - field 000 blocks source regardless of enable
// - unimplemented bits read zero, ignore writes
// - reset: enables zero, fields 100
// - fourth enable word bit layout
// - fifth enable word upper byte layout
// - fifth enable word lower byte layout
// - priority word zero four fields
// - priority word one three fields, low nibble unused
// - priority word two four fields
// - bits 15, 11, 7, 3 unimplemented
//
// Design decisions made here: the register addresses and the APB register port.
module iep_regs #(
	parameter int AW = 12,
	parameter int LANES = 12
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// peripheral flags, same clock
	input wire logic [15:0] enFlag4,
	input wire logic [15:0] enFlag5,
	input wire logic [LANES-1:0] prioFlag,
	input wire logic [LANES-1:0] prioSrcEn,
	// requests to the core
	output logic [15:0] enReq4,
	output logic [15:0] enReq5,
	output logic [LANES-1:0] prioReq,
	output logic [LANES*3-1:0] prioLevel,
	output logic topValid,
	output logic [2:0] topLevel,
	// interrupt
	output logic irq
);
	logic [15:0] en4_q;
	logic [15:0] en5_q;
	logic [15:0] pr0_q;
	logic [15:0] pr1_q;
	logic [15:0] pr2_q;
	logic [1:0] stat_q;
	logic [1:0] stat_d;
	logic [1:0] mask_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [15:0] enReq4_q;
	logic [15:0] enReq5_q;
	logic [LANES-1:0] prioReq_q;
	logic [LANES-1:0] prioReq_d;
	logic [LANES*3-1:0] prioLevel_q;
	logic [LANES*3-1:0] prioLevel_d;
	logic topValid_q;
	logic [2:0] topLevel_q;
	logic [2:0] topLevel_d;
	logic irq_q;

	// byte-lane merge, then drop unimplemented positions
	function automatic logic [15:0] mergeW(
		input logic [15:0] old,
		input logic [15:0] msk,
		input logic [15:0] wd,
		input logic [1:0] strb
	);
		logic [15:0] m;
		m[7:0] = strb[0] ? wd[7:0] : old[7:0];
		m[15:8] = strb[1] ? wd[15:8] : old[15:8];
		return m & msk;
	endfunction

	// lane n lives in word n/4, nibble n%4
	function automatic logic [2:0] fieldOf(
		input logic [47:0] all,
		input int n
	);
		return all[n*iep_pkg::NIB +: iep_pkg::FW];
	endfunction

	// apb decode
	wire logic access = psel & penable;
	wire logic done = access & pready_q;
	wire logic wrDone = done & pwrite;
	wire logic selEn4 = paddr == AW'(iep_pkg::OFS_EN4);
	wire logic selEn5 = paddr == AW'(iep_pkg::OFS_EN5);
	wire logic selPr0 = paddr == AW'(iep_pkg::OFS_PR0);
	wire logic selPr1 = paddr == AW'(iep_pkg::OFS_PR1);
	wire logic selPr2 = paddr == AW'(iep_pkg::OFS_PR2);
	wire logic selStat = paddr == AW'(iep_pkg::OFS_STAT);
	wire logic selMask = paddr == AW'(iep_pkg::OFS_MASK);
	wire logic mapped = selEn4 | selEn5 | selPr0 | selPr1
		| selPr2 | selStat | selMask;
	wire logic [15:0] wd16 = pwdata[15:0];
	wire logic [1:0] st2 = pstrb[1:0];

	// read mux, upper half always zero
	wire logic [15:0] rd16 =
		selEn4 ? en4_q :
		selEn5 ? en5_q :
		selPr0 ? pr0_q :
		selPr1 ? pr1_q :
		selPr2 ? pr2_q :
		selStat ? {14'h0000, stat_q} :
		selMask ? {14'h0000, mask_q} : 16'h0000;

	// gated requests of the enable words
	wire logic [15:0] enReq4_d = enFlag4 & en4_q;
	wire logic [15:0] enReq5_d = enFlag5 & en5_q;
	wire logic [47:0] prAll = {pr2_q, pr1_q, pr0_q};

	always_comb begin
		prioReq_d = '0;
		prioLevel_d = '0;
		topLevel_d = iep_pkg::PRIO_OFF;
		for (int i = 0; i < LANES; i++) begin
			// level equals field value, 000 kills the source
			if (prioFlag[i] && prioSrcEn[i]
				&& fieldOf(prAll, i) != iep_pkg::PRIO_OFF) begin
				prioReq_d[i] = 1'b1;
				prioLevel_d[i*3 +: 3] = fieldOf(prAll, i);
				if (fieldOf(prAll, i) > topLevel_d) begin
					topLevel_d = fieldOf(prAll, i);
				end
			end
		end
	end

	// events: any request newly raised
	wire logic prioRise = |(prioReq_d & ~prioReq_q);
	wire logic gateRise = |({enReq5_d, enReq4_d} & ~{enReq5_q, enReq4_q});
	wire logic [1:0] clrBits = (wrDone && selStat && st2[0]) ? pwdata[1:0] : 2'h0;
	wire logic [1:0] setBits = {gateRise, prioRise};

	// a set in the clear cycle wins
	assign stat_d = (stat_q & ~clrBits) | setBits;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			en4_q <= iep_pkg::RST_EN;
			en5_q <= iep_pkg::RST_EN;
			pr0_q <= iep_pkg::RST_PR & iep_pkg::MASK_PR0;
			pr1_q <= iep_pkg::RST_PR & iep_pkg::MASK_PR1;
			pr2_q <= iep_pkg::RST_PR & iep_pkg::MASK_PR2;
		end else if (wrDone) begin
			// masks hold the field layout of each word
			if (selEn4) begin
				en4_q <= mergeW(en4_q, iep_pkg::MASK_EN4, wd16, st2);
			end
			if (selEn5) begin
				en5_q <= mergeW(en5_q, iep_pkg::MASK_EN5, wd16, st2);
			end
			if (selPr0) begin
				pr0_q <= mergeW(pr0_q, iep_pkg::MASK_PR0, wd16, st2);
			end
			if (selPr1) begin
				pr1_q <= mergeW(pr1_q, iep_pkg::MASK_PR1, wd16, st2);
			end
			if (selPr2) begin
				pr2_q <= mergeW(pr2_q, iep_pkg::MASK_PR2, wd16, st2);
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			stat_q <= iep_pkg::RST_ST;
			mask_q <= iep_pkg::RST_ST;
		end else begin
			stat_q <= stat_d;
			if (wrDone && selMask && st2[0]) begin
				mask_q <= pwdata[1:0];
			end
		end
	end

	// one wait state so that read data comes from a flop
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else if (access && !pready_q) begin
			pready_q <= 1'b1;
			pslverr_q <= !mapped;
			prdata_q <= pwrite ? 32'h00000000 : {16'h0000, rd16};
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			enReq4_q <= 16'h0000;
			enReq5_q <= 16'h0000;
			prioReq_q <= '0;
			prioLevel_q <= '0;
			topValid_q <= 1'b0;
			topLevel_q <= iep_pkg::PRIO_OFF;
			irq_q <= 1'b0;
		end else begin
			enReq4_q <= enReq4_d;
			enReq5_q <= enReq5_d;
			prioReq_q <= prioReq_d;
			prioLevel_q <= prioLevel_d;
			topValid_q <= |prioReq_d;
			topLevel_q <= topLevel_d;
			irq_q <= |(stat_q & mask_q);
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign enReq4 = enReq4_q;
	assign enReq5 = enReq5_q;
	assign prioReq = prioReq_q;
	assign prioLevel = prioLevel_q;
	assign topValid = topValid_q;
	assign topLevel = topLevel_q;
	assign irq = irq_q;

	// checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	property p_en_pass;
		(enFlag4[13] && en4_q[13]) |=> enReq4_q[13];
	endproperty
	a_en_pass: assert property (p_en_pass)
		else $error("enabled request not passed");

	property p_en_block;
		!en5_q[6] |=> !enReq5_q[6];
	endproperty
	a_en_block: assert property (p_en_block)
		else $error("disabled request passed");

	property p_top_level;
		(prioFlag[0] && prioSrcEn[0] && pr0_q[2:0] == 3'h7)
			|=> prioReq_q[0] && prioLevel_q[2:0] == 3'h7 && topLevel_q == 3'h7;
	endproperty
	a_top_level: assert property (p_top_level)
		else $error("level 7 not presented");

	property p_low_level;
		(prioFlag[11] && prioSrcEn[11] && pr2_q[14:12] == 3'h1)
			|=> prioLevel_q[35:33] == 3'h1;
	endproperty
	a_low_level: assert property (p_low_level)
		else $error("level 1 not presented");

	property p_zero_off;
		(pr1_q[10:8] == 3'h0) |=> !prioReq_q[6] && prioLevel_q[20:18] == 3'h0;
	endproperty
	a_zero_off: assert property (p_zero_off)
		else $error("zero field still requests");

	property p_unimpl;
		(en4_q & 16'hDEF1) == 16'h0000 && (en5_q & 16'hC001) == 16'h0000
			&& (pr1_q & 16'h000F) == 16'h0000 && prdata_q[31:16] == 16'h0000;
	endproperty
	a_unimpl: assert property (p_unimpl)
		else $error("unimplemented bit set");

	property p_reset_vals;
		@(posedge ref_clk) disable iff (1'b0)
		!reset_n && $past(!reset_n) |-> en4_q == 16'h0000 && en5_q == 16'h0000
			&& pr0_q == 16'h4444 && pr1_q == 16'h4440 && pr2_q == 16'h4444;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("wrong reset value");

	property p_resv;
		((pr0_q | pr1_q | pr2_q) & 16'h8888) == 16'h0000;
	endproperty
	a_resv: assert property (p_resv)
		else $error("reserved priority bit set");

	property p_need_flag;
		prioReq_q[7] |-> $past(prioFlag[7] && prioSrcEn[7] && pr1_q[14:12] != 3'h0);
	endproperty
	a_need_flag: assert property (p_need_flag)
		else $error("request without cause");

	property p_apb_wait;
		(access && !pready_q) |=> pready_q ##1 !pready_q;
	endproperty
	a_apb_wait: assert property (p_apb_wait)
		else $error("apb answer timing wrong");

	property p_irq;
		(stat_q[0] && mask_q[0]) |=> irq_q;
	endproperty
	a_irq: assert property (p_irq)
		else $error("irq not raised");

	property p_irq_off;
		((stat_q & mask_q) == 2'h0) |=> !irq_q;
	endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("irq without unmasked status");

	property p_set_wins;
		prioRise |=> stat_q[0];
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("status event lost");

	property p_wr_en4;
		(wrDone && selEn4 && st2 == 2'h3) |=> en4_q == ($past(wd16) & 16'h210E);
	endproperty
	a_wr_en4: assert property (p_wr_en4)
		else $error("enable word 4 write wrong");

	property p_wr_en5;
		(wrDone && selEn5 && st2 == 2'h3) |=> en5_q == ($past(wd16) & 16'h3FFE);
	endproperty
	a_wr_en5: assert property (p_wr_en5)
		else $error("enable word 5 write wrong");

	property p_wr_pr0;
		(wrDone && selPr0 && st2 == 2'h3) |=> pr0_q == ($past(wd16) & 16'h7777);
	endproperty
	a_wr_pr0: assert property (p_wr_pr0)
		else $error("priority word 0 write wrong");

	property p_wr_pr1;
		(wrDone && selPr1 && st2 == 2'h3) |=> pr1_q == ($past(wd16) & 16'h7770);
	endproperty
	a_wr_pr1: assert property (p_wr_pr1)
		else $error("priority word 1 write wrong");

	property p_wr_pr2;
		(wrDone && selPr2 && st2 == 2'h3) |=> pr2_q == ($past(wd16) & 16'h7777);
	endproperty
	a_wr_pr2: assert property (p_wr_pr2)
		else $error("priority word 2 write wrong");

	property p_byte_keep;
		(wrDone && selPr2 && !st2[1]) |=> pr2_q[15:8] == $past(pr2_q[15:8]);
	endproperty
	a_byte_keep: assert property (p_byte_keep)
		else $error("unstrobed byte changed");

	property p_slverr;
		(access && !pready_q && !mapped) |=> pslverr_q && prdata_q == 32'h00000000;
	endproperty
	a_slverr: assert property (p_slverr)
		else $error("unmapped access not refused");

	property p_rd_idle;
		!pready_q |-> prdata_q == 32'h00000000 && !pslverr_q;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("bus outputs not idle");

	c_wr_en4: cover property (wrDone && selEn4);
	c_top7: cover property (topValid_q && topLevel_q == 3'h7);
	c_irq: cover property ($rose(irq_q));
	c_slverr: cover property (pslverr_q);
endmodule

// >>> tb/iep_src_model.sv
module iep_src_model (
	// clock
	input wire logic ref_clk,
	// flag levels toward the block
	output logic [15:0] enFlag4,
	output logic [15:0] enFlag5,
	output logic [11:0] prioFlag,
	output logic [11:0] prioSrcEn
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		enFlag4 = 16'h0000;
		enFlag5 = 16'h0000;
		prioFlag = 12'h000;
		prioSrcEn = 12'h000;
	end
	// sources hold a flag as a level until the next drive call
	task automatic drive(input logic [15:0] f4, input logic [15:0] f5,
		input logic [11:0] pf, input logic [11:0] pe);
		@(posedge ref_clk);
		enFlag4 <= f4;
		enFlag5 <= f5;
		prioFlag <= pf;
		prioSrcEn <= pe;
	endtask
endmodule

// >>> tb/irq_enable_priority_regs_tb.sv
module irq_enable_priority_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic reset_n;
	logic psel, penable, pwrite, pready, pslverr, topValid, irq, err;
	logic [11:0] paddr, prioFlag, prioSrcEn, prioReq;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [15:0] enFlag4, enFlag5, enReq4, enReq5;
	logic [35:0] prioLevel;
	logic [2:0] topLevel;
	int n_mismatch = 0;
	int check_count = 0;
	int cycles = 0;
	logic [11:0] ofs [5] = '{iep_pkg::OFS_EN4, iep_pkg::OFS_EN5, iep_pkg::OFS_PR0,
		iep_pkg::OFS_PR1, iep_pkg::OFS_PR2};
	logic [15:0] rstVal [5] = '{16'h0000, 16'h0000, 16'h4444, 16'h4440, 16'h4444};
	logic [15:0] rwMask [5] = '{iep_pkg::MASK_EN4, iep_pkg::MASK_EN5, 16'h7777, 16'h7770,
		16'h7777};
	// word0, word1, word2, lane flags, lane enables
	logic [71:0] vecs [4] = '{72'h7103_0000_0000_FFF_FFF, 72'h0000_2650_1234_FFF_FFF,
		72'h7777_7770_7777_0A5_FFF, 72'h5555_5550_5555_FFF_5A5};

	always #10 ref_clk = ~ref_clk;

	iep_src_model src_u (.ref_clk(ref_clk), .enFlag4(enFlag4), .enFlag5(enFlag5),
		.prioFlag(prioFlag), .prioSrcEn(prioSrcEn));

	iep_regs dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .enFlag4(enFlag4), .enFlag5(enFlag5),
		.prioFlag(prioFlag), .prioSrcEn(prioSrcEn), .enReq4(enReq4), .enReq5(enReq5),
		.prioReq(prioReq), .prioLevel(prioLevel), .topValid(topValid),
		.topLevel(topLevel), .irq(irq));

	task automatic summarize();
		if (n_mismatch == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [47:0] a, input logic [47:0] e);
		check_count++;
		if (a !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, a, e);
		end
	endtask

	// one apb transfer; read data and error taken at the pready edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// expected lane outputs worked out from the written words
	task automatic chkPrio(input logic [47:0] words);
		logic [35:0] lv;
		logic [11:0] rq;
		logic [2:0] f;
		logic [2:0] top;
		top = 3'h0;
		for (int n = 0; n < 12; n++) begin
			f = words[16 * (n / 4) + 4 * (n % 4) +: 3];
			if (n == 4 || prioFlag[n] !== 1'b1 || prioSrcEn[n] !== 1'b1)
				f = 3'h0;
			lv[3 * n +: 3] = f;
			rq[n] = |f;
			if (f > top)
				top = f;
		end
		chk(prioLevel, lv);
		chk(prioReq, rq);
		chk({topValid, topLevel}, {|rq, top});
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			summarize();
		end
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hF;
		reset_n = 1'b0;
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			xfer(1'b0, ofs[i], 32'h00000000);
			chk(rd, rstVal[i]);
		end
		for (int i = 0; i < 5; i++) begin
			xfer(1'b1, ofs[i], 32'hFFFFFFFF);
			xfer(1'b0, ofs[i], 32'h00000000);
			chk(rd, rwMask[i]);
		end
		// low byte strobe only: upper byte keeps its value
		pstrb <= 4'h1;
		xfer(1'b1, iep_pkg::OFS_PR2, 32'h00000000);
		pstrb <= 4'hF;
		xfer(1'b0, iep_pkg::OFS_PR2, 32'h00000000);
		chk(rd, 16'h7700);
		xfer(1'b0, 12'h01C, 32'h00000000);
		chk({err, rd}, {1'b1, 32'h00000000});
		src_u.drive(16'hFFFF, 16'hFFFF, 12'h000, 12'h000);
		repeat (2) @(posedge ref_clk);
		chk({enReq5, enReq4}, {iep_pkg::MASK_EN5, iep_pkg::MASK_EN4});
		xfer(1'b1, iep_pkg::OFS_EN4, 32'h00002000);
		xfer(1'b1, iep_pkg::OFS_EN5, 32'h00000000);
		repeat (2) @(posedge ref_clk);
		chk({enReq5, enReq4}, {16'h0000, 16'h2000});
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, iep_pkg::OFS_PR0, {16'h0000, vecs[i][71:56]});
			xfer(1'b1, iep_pkg::OFS_PR1, {16'h0000, vecs[i][55:40]});
			xfer(1'b1, iep_pkg::OFS_PR2, {16'h0000, vecs[i][39:24]});
			src_u.drive(16'h0000, 16'h0000, vecs[i][23:12], vecs[i][11:0]);
			repeat (2) @(posedge ref_clk);
			chkPrio({vecs[i][39:24], vecs[i][55:40], vecs[i][71:56]});
		end
		// interrupt: drop flags, clear, raise masked, unmask, clear again
		src_u.drive(16'h0000, 16'h0000, 12'h000, 12'h000);
		xfer(1'b1, iep_pkg::OFS_MASK, 32'h00000000);
		xfer(1'b1, iep_pkg::OFS_STAT, 32'h00000003);
		xfer(1'b0, iep_pkg::OFS_STAT, 32'h00000000);
		chk({irq, rd}, {1'b0, 32'h00000000});
		src_u.drive(16'h0000, 16'h0000, 12'h001, 12'h001);
		xfer(1'b0, iep_pkg::OFS_STAT, 32'h00000000);
		chk({irq, rd}, {1'b0, 32'h00000001});
		xfer(1'b1, iep_pkg::OFS_MASK, 32'h00000001);
		repeat (3) @(posedge ref_clk);
		chk(irq, 1'b1);
		xfer(1'b1, iep_pkg::OFS_STAT, 32'h00000001);
		repeat (3) @(posedge ref_clk);
		chk(irq, 1'b0);
		// mid-run reset brings written words back to defaults
		reset_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		xfer(1'b0, iep_pkg::OFS_EN4, 32'h00000000);
		chk(rd, 16'h0000);
		xfer(1'b0, iep_pkg::OFS_PR0, 32'h00000000);
		chk(rd, 16'h4444);
		xfer(1'b0, iep_pkg::OFS_MASK, 32'h00000000);
		chk({irq, rd}, {1'b0, 32'h00000000});
		summarize();
	end
endmodule
